// ==== include/sanc_pkg.sv ====
// Constants and types of the scalar arithmetic unit.
package sanc_pkg;

  localparam int SANC_DATA_W  = 32;
  localparam int SANC_DEST_W  = 4;
  localparam int SANC_POINT_W = 6;

  // Latencies in cycles from issue to result.
  localparam int SANC_LAT_ONE  = 1;
  localparam int SANC_LAT_MUL  = 3;
  localparam int SANC_LAT_LONG = 4;

  // Angle field of the sine/cosine input.
  localparam int SANC_ANGLE_LSB = 12;
  localparam int SANC_ANGLE_W   = 20;

  // Gain-compensated CORDIC start magnitude.
  localparam logic signed [17:0] SANC_CORDIC_X0 = 18'sh04DB9;
  localparam logic signed [15:0] SANC_SIN_MAX   = 16'sh7FFF;
  localparam logic signed [15:0] SANC_SIN_MIN   = -16'sh7FFF - 16'sh0001;

  // Arctangent of 2^-i, in units of one full turn over 2^20.
  localparam logic signed [20:0] SANC_ATAN [0:15] = '{
    21'sh20000, 21'sh12E40, 21'sh09FB4, 21'sh05111,
    21'sh028B1, 21'sh0145D, 21'sh00A2F, 21'sh00518,
    21'sh0028C, 21'sh00146, 21'sh000A3, 21'sh00051,
    21'sh00029, 21'sh00014, 21'sh0000A, 21'sh00005};

  // Single-precision constants.
  localparam int            SANC_FP_BIAS   = 127;
  localparam logic [31:0]   SANC_FP_QNAN   = 32'h7FC00000;
  localparam logic [47:0]   SANC_RECIP_NUM = 48'h800000000000;
  localparam logic [7:0]    SANC_RECIP_TOP = 8'hFD;

  // Fixed-point saturation bounds and conversion exponent limits.
  localparam logic [31:0] SANC_INT_MAX      = 32'h7FFFFFFF;
  localparam logic [31:0] SANC_INT_MIN      = 32'h80000000;
  localparam int          SANC_FIX_SAT_EXP  = 31;
  localparam int          SANC_FIX_WRAP_EXP = 129;

  typedef enum logic [4:0] {
    op_add,
    op_sub,
    bitwise_and_op,
    bitwise_or_op,
    bitwise_xor_op,
    op_mul,
    op_shift,
    op_sincos,
    absolute_value_op,
    leading_zero_count_op,
    lesser_select_op,
    greater_select_op,
    op_fsqrt,
    op_frsqrt,
    op_frecip,
    op_fabs,
    op_fmin,
    op_fmax,
    fixed_to_float_conv,
    float_to_fixed_conv
  } sanc_op_type;

  typedef enum logic [1:0] {
    lat_one,
    lat_mul,
    lat_long
  } sanc_lat_type;

  function automatic sanc_lat_type sanc_lat_of(input sanc_op_type op);
    case (op)
      op_mul:    return lat_mul;
      op_sincos,
      op_fsqrt,
      op_frsqrt,
      op_frecip: return lat_long;
      default:   return lat_one;
    endcase
  endfunction : sanc_lat_of

endpackage : sanc_pkg

// ==== include/sanc_cordic_if.sv ====
// Carrier for the rotation state passed between CORDIC pipeline stages.
`timescale 1ns/100ps
interface sanc_cordic_if;
  logic signed [17:0] x;
  logic signed [17:0] y;
  logic signed [20:0] z;

  modport src (output x, output y, output z);
  modport dst (input x, input y, input z);
endinterface : sanc_cordic_if

// ==== logic/sanc_cordic_stage.sv ====
// One registered group of CORDIC rotation iterations.
`timescale 1ns/100ps
module sanc_cordic_stage
  import sanc_pkg::*;
#(
  parameter int FIRST = 0,
  parameter int COUNT = 4
)(
  input  wire logic   sys_clk_i,
  input  wire logic   reset_i,
  sanc_cordic_if.dst  prev,
  sanc_cordic_if.src  next
);

  logic signed [17:0] x_reg;
  logic signed [17:0] y_reg;
  logic signed [20:0] z_reg;
  logic signed [17:0] x_next;
  logic signed [17:0] y_next;
  logic signed [20:0] z_next;
  logic signed [17:0] dx;
  logic signed [17:0] dy;

  // Each iteration drives the residual angle to zero.
  always_comb
  begin
    x_next = prev.x;
    y_next = prev.y;
    z_next = prev.z;
    dx     = 18'sh00000;
    dy     = 18'sh00000;
    for (int i = 0; i < COUNT; i++)
    begin
      dx = x_next >>> (FIRST + i);
      dy = y_next >>> (FIRST + i);
      if (!z_next[20])
      begin
        x_next = x_next - dy;
        y_next = y_next + dx;
        z_next = z_next - SANC_ATAN[FIRST + i];
      end
      else
      begin
        x_next = x_next + dy;
        y_next = y_next - dx;
        z_next = z_next + SANC_ATAN[FIRST + i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      x_reg <= 18'sh00000;
      y_reg <= 18'sh00000;
      z_reg <= 21'sh00000;
    end
    else
    begin
      x_reg <= x_next;
      y_reg <= y_next;
      z_reg <= z_next;
    end
  end

  assign next.x = x_reg;
  assign next.y = y_reg;
  assign next.z = z_reg;

endmodule : sanc_cordic_stage

// ==== logic/sanc_scalar_alu.sv ====
// Pipelined scalar arithmetic unit with three write ports.
//
// Notes on behaviour
// - Issue every cycle.
// - Add, subtract, one cycle.
// - Bitwise AND, OR, XOR, one cycle.
// - Multiply, three cycles.
// - Signed shift, one cycle.
// - Sine/cosine, four cycles.
// - Absolute value by invert plus one.
// - Leading zero count, one cycle.
// - Lesser or greater of two, one cycle.
// - Float roots, reciprocal, four cycles.
// - Float abs, min, max, one cycle.
// - Conversions with point operand, one cycle.
// - Fraction count is signed six bits.
// - Huge input, positive count: zero.
// - Most negative result flags overflow.
`timescale 1ns/100ps
module sanc_scalar_alu
  import sanc_pkg::*;
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    issue_valid_i,
  input  wire sanc_op_type             issue_op_i,
  input  wire logic [SANC_DEST_W-1:0]  issue_dest_i,
  input  wire logic [SANC_DATA_W-1:0]  src_a_i,
  input  wire logic [SANC_DATA_W-1:0]  src_b_i,
  input  wire logic                    shift_neg_i,
  input  wire logic [SANC_POINT_W-1:0] point_i,
  output logic                         wb1_valid_o,
  output logic [SANC_DEST_W-1:0]       wb1_dest_o,
  output logic [SANC_DATA_W-1:0]       wb1_data_o,
  output logic                         wb1_overflow_o,
  output logic                         wb3_valid_o,
  output logic [SANC_DEST_W-1:0]       wb3_dest_o,
  output logic [SANC_DATA_W-1:0]       wb3_data_o,
  output logic                         wb4_valid_o,
  output logic [SANC_DEST_W-1:0]       wb4_dest_o,
  output logic [SANC_DATA_W-1:0]       wb4_data_o
);

  function automatic logic [5:0] clz32(input logic [31:0] a);
    logic [5:0] n;
    logic       seen;
    n    = 6'h00;
    seen = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      if (a[i])
        seen = 1'b1;
      else if (!seen)
        n = n + 6'h01;
    end
    return n;
  endfunction : clz32

  // Float order key for one unsigned compare.
  function automatic logic [31:0] fp_key(input logic [31:0] a);
    return a[31] ? ~a : {1'b1, a[30:0]};
  endfunction : fp_key

  function automatic logic [31:0] fix_to_float(input logic [31:0] a, input logic [5:0] p);
    logic [31:0] mag;
    logic [31:0] norm;
    logic [5:0]  lz;
    int          ex;
    mag = a[31] ? (~a + 32'h00000001) : a;
    if (mag == 32'h00000000)
      return 32'h00000000;
    lz   = clz32(mag);
    norm = mag << lz;
    ex   = SANC_FP_BIAS + 31 - int'(lz) - int'($signed(p));
    return {a[31], 8'(ex), norm[30:8]};
  endfunction : fix_to_float

  // Overflow flag in the top bit.
  function automatic logic [32:0] float_to_fix(input logic [31:0] n, input logic [5:0] sft);
    logic [23:0] m;
    logic [31:0] mag;
    int          ex;
    int          k;
    ex = int'(n[30:23]) - SANC_FP_BIAS + int'($signed(sft));
    m  = {1'b1, n[22:0]};
    if (n[30:23] == 8'hFF)
      return {1'b1, (n[31] && n[22:0] == 23'h000000) ? SANC_INT_MIN : SANC_INT_MAX};
    if (n[30:23] == 8'h00 || ex < 0)
      return 33'h000000000;
    if ($signed(sft) > 0 && ex >= SANC_FIX_WRAP_EXP)
      return {1'b1, 32'h00000000};
    if (ex >= SANC_FIX_SAT_EXP)
      return {1'b1, n[31] ? SANC_INT_MIN : SANC_INT_MAX};
    k   = ex - 23;
    mag = (k >= 0) ? 32'({8'h00, m} << k) : 32'({8'h00, m} >> (-k));
    return {1'b0, n[31] ? (~mag + 32'h00000001) : mag};
  endfunction : float_to_fix

  function automatic logic [31:0] fp_sqrt(input logic [31:0] a);
    logic [7:0]  e;
    logic [47:0] rad;
    logic [23:0] root;
    logic [23:0] t;
    logic [8:0]  ex;
    e = a[30:23];
    if (e == 8'h00)
      return {a[31], 31'h00000000};
    if (a[31])
      return SANC_FP_QNAN;
    if (e == 8'hFF)
      return a;
    rad  = e[0] ? {1'b0, 1'b1, a[22:0], 23'h000000} : {1'b1, a[22:0], 24'h000000};
    root = 24'h000000;
    for (int i = 23; i >= 0; i--)
    begin
      t = root | (24'h000001 << i);
      if ({24'h000000, t} * {24'h000000, t} <= rad)
        root = t;
    end
    ex = ({1'b0, e} + 9'h07E + {8'h00, e[0]}) >> 1;
    return {1'b0, ex[7:0], root[22:0]};
  endfunction : fp_sqrt

  function automatic logic [31:0] fp_recip(input logic [31:0] a);
    logic [7:0]  e;
    logic [24:0] q;
    e = a[30:23];
    if (e == 8'hFF)
      return (a[22:0] != 23'h000000) ? SANC_FP_QNAN : {a[31], 31'h00000000};
    if (e == 8'h00)
      return {a[31], 8'hFF, 23'h000000};
    if (e >= SANC_RECIP_TOP)
      return {a[31], 31'h00000000};
    q = 25'(SANC_RECIP_NUM / {24'h000000, 1'b1, a[22:0]});
    if (q[24])
      return {a[31], 8'(9'h0FE - {1'b0, e}), 23'h000000};
    return {a[31], 8'(9'h0FD - {1'b0, e}), q[22:0]};
  endfunction : fp_recip

  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'(SANC_SIN_MAX))
      return SANC_SIN_MAX;
    if (v < 18'(SANC_SIN_MIN))
      return SANC_SIN_MIN;
    return v[15:0];
  endfunction : sat16

  sanc_lat_type       issue_lat;
  logic [31:0]        res1;
  logic               ovf1;
  logic signed [31:0] sh_amt;
  logic signed [31:0] sh_mag;
  logic [32:0]        conv_res;

  logic                   wb1_valid_reg;
  logic [SANC_DEST_W-1:0] wb1_dest_reg;
  logic [31:0]            wb1_data_reg;
  logic                   wb1_ovf_reg;

  logic                   mul_valid_reg [0:SANC_LAT_MUL-2];
  logic [SANC_DEST_W-1:0] mul_dest_reg  [0:SANC_LAT_MUL-2];
  logic [31:0]            mul_prod_reg  [0:SANC_LAT_MUL-2];
  logic                   wb3_valid_reg;
  logic [SANC_DEST_W-1:0] wb3_dest_reg;
  logic [31:0]            wb3_data_reg;

  logic                   long_valid_reg [0:SANC_LAT_LONG-2];
  logic [SANC_DEST_W-1:0] long_dest_reg  [0:SANC_LAT_LONG-2];
  sanc_op_type            long_op_reg    [0:SANC_LAT_LONG-2];
  logic [31:0]            long_fp_reg    [0:SANC_LAT_LONG-2];
  logic                   wb4_valid_reg;
  logic [SANC_DEST_W-1:0] wb4_dest_reg;
  logic [31:0]            wb4_data_reg;

  logic [SANC_ANGLE_W-1:0] angle;

  assign issue_lat = sanc_lat_of(issue_op_i);
  assign sh_amt    = shift_neg_i ? -$signed(src_b_i) : $signed(src_b_i);
  assign sh_mag    = -sh_amt;
  assign conv_res  = float_to_fix(src_a_i, point_i);

  // Single-cycle operations share one write port.
  always_comb
  begin
    res1 = 32'h00000000;
    ovf1 = 1'b0;
    case (issue_op_i)
      op_add:                res1 = src_a_i + src_b_i;
      op_sub:                res1 = src_a_i - src_b_i;
      bitwise_and_op:        res1 = src_a_i & src_b_i;
      bitwise_or_op:         res1 = src_a_i | src_b_i;
      bitwise_xor_op:        res1 = src_a_i ^ src_b_i;
      op_shift:
      begin
        if (sh_amt >= 32)
          res1 = 32'h00000000;
        else if (sh_amt >= 0)
          res1 = src_a_i << sh_amt[4:0];
        else if (sh_amt <= -32)
          res1 = {32{src_a_i[31]}};
        else
          res1 = 32'($signed(src_a_i) >>> sh_mag[4:0]);
      end
      absolute_value_op:     res1 = src_a_i[31] ? (~src_a_i + 32'h00000001) : src_a_i;
      leading_zero_count_op: res1 = {26'h0000000, clz32(src_a_i)};
      lesser_select_op:      res1 = ($signed(src_a_i) < $signed(src_b_i)) ? src_a_i : src_b_i;
      greater_select_op:     res1 = ($signed(src_a_i) > $signed(src_b_i)) ? src_a_i : src_b_i;
      op_fabs:               res1 = {1'b0, src_a_i[30:0]};
      op_fmin:               res1 = (fp_key(src_a_i) < fp_key(src_b_i)) ? src_a_i : src_b_i;
      op_fmax:               res1 = (fp_key(src_a_i) > fp_key(src_b_i)) ? src_a_i : src_b_i;
      fixed_to_float_conv:   res1 = fix_to_float(src_a_i, point_i);
      float_to_fixed_conv:
      begin
        res1 = conv_res[31:0];
        ovf1 = conv_res[32];
      end
      default:               res1 = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wb1_valid_reg <= 1'b0;
      wb1_dest_reg  <= '0;
      wb1_data_reg  <= 32'h00000000;
      wb1_ovf_reg   <= 1'b0;
    end
    else
    begin
      wb1_valid_reg <= issue_valid_i && issue_lat == lat_one;
      wb1_dest_reg  <= issue_dest_i;
      wb1_data_reg  <= res1;
      wb1_ovf_reg   <= issue_valid_i && issue_lat == lat_one && ovf1;
    end
  end

  // Multiply pipeline, one entry per edge.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < SANC_LAT_MUL - 1; i++)
      begin
        mul_valid_reg[i] <= 1'b0;
        mul_dest_reg[i]  <= '0;
        mul_prod_reg[i]  <= 32'h00000000;
      end
      wb3_valid_reg <= 1'b0;
      wb3_dest_reg  <= '0;
      wb3_data_reg  <= 32'h00000000;
    end
    else
    begin
      mul_valid_reg[0] <= issue_valid_i && issue_lat == lat_mul;
      mul_dest_reg[0]  <= issue_dest_i;
      mul_prod_reg[0]  <= 32'(src_a_i * src_b_i);
      for (int i = 1; i < SANC_LAT_MUL - 1; i++)
      begin
        mul_valid_reg[i] <= mul_valid_reg[i-1];
        mul_dest_reg[i]  <= mul_dest_reg[i-1];
        mul_prod_reg[i]  <= mul_prod_reg[i-1];
      end
      wb3_valid_reg <= mul_valid_reg[SANC_LAT_MUL-2];
      wb3_dest_reg  <= mul_dest_reg[SANC_LAT_MUL-2];
      wb3_data_reg  <= mul_prod_reg[SANC_LAT_MUL-2];
    end
  end

  // Start vector pre-rotated by quadrant.
  sanc_cordic_if c0();
  sanc_cordic_if c1();
  sanc_cordic_if c2();
  sanc_cordic_if c3();

  assign angle = src_a_i[SANC_ANGLE_LSB +: SANC_ANGLE_W];
  assign c0.z  = {3'b000, angle[17:0]};
  assign c0.x  = (angle[19:18] == 2'h0) ? SANC_CORDIC_X0 :
                 (angle[19:18] == 2'h2) ? -SANC_CORDIC_X0 : 18'sh00000;
  assign c0.y  = (angle[19:18] == 2'h1) ? SANC_CORDIC_X0 :
                 (angle[19:18] == 2'h3) ? -SANC_CORDIC_X0 : 18'sh00000;

  sanc_cordic_stage #(.FIRST(0), .COUNT(6)) u_stage0 (.sys_clk_i, .reset_i, .prev(c0), .next(c1));
  sanc_cordic_stage #(.FIRST(6), .COUNT(6)) u_stage1 (.sys_clk_i, .reset_i, .prev(c1), .next(c2));
  sanc_cordic_stage #(.FIRST(12), .COUNT(4)) u_stage2 (.sys_clk_i, .reset_i, .prev(c2), .next(c3));

  // Root in stage two, reciprocal in stage three.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < SANC_LAT_LONG - 1; i++)
      begin
        long_valid_reg[i] <= 1'b0;
        long_dest_reg[i]  <= '0;
        long_op_reg[i]    <= op_add;
        long_fp_reg[i]    <= 32'h00000000;
      end
      wb4_valid_reg <= 1'b0;
      wb4_dest_reg  <= '0;
      wb4_data_reg  <= 32'h00000000;
    end
    else
    begin
      long_valid_reg[0] <= issue_valid_i && issue_lat == lat_long;
      long_dest_reg[0]  <= issue_dest_i;
      long_op_reg[0]    <= issue_op_i;
      long_fp_reg[0]    <= src_a_i;
      for (int i = 1; i < SANC_LAT_LONG - 1; i++)
      begin
        long_valid_reg[i] <= long_valid_reg[i-1];
        long_dest_reg[i]  <= long_dest_reg[i-1];
        long_op_reg[i]    <= long_op_reg[i-1];
      end
      long_fp_reg[1] <= (long_op_reg[0] == op_fsqrt || long_op_reg[0] == op_frsqrt) ?
                        fp_sqrt(long_fp_reg[0]) : long_fp_reg[0];
      long_fp_reg[2] <= (long_op_reg[1] == op_frecip || long_op_reg[1] == op_frsqrt) ?
                        fp_recip(long_fp_reg[1]) : long_fp_reg[1];
      wb4_valid_reg <= long_valid_reg[SANC_LAT_LONG-2];
      wb4_dest_reg  <= long_dest_reg[SANC_LAT_LONG-2];
      wb4_data_reg  <= (long_op_reg[SANC_LAT_LONG-2] == op_sincos) ?
                       {sat16(c3.y), sat16(c3.x)} : long_fp_reg[SANC_LAT_LONG-2];
    end
  end

  assign wb1_valid_o    = wb1_valid_reg;
  assign wb1_dest_o     = wb1_dest_reg;
  assign wb1_data_o     = wb1_data_reg;
  assign wb1_overflow_o = wb1_ovf_reg;
  assign wb3_valid_o    = wb3_valid_reg;
  assign wb3_dest_o     = wb3_dest_reg;
  assign wb3_data_o     = wb3_data_reg;
  assign wb4_valid_o    = wb4_valid_reg;
  assign wb4_dest_o     = wb4_dest_reg;
  assign wb4_data_o     = wb4_data_reg;

endmodule : sanc_scalar_alu

// ==== verification/sanc_scalar_alu_monitor.sv ====
// Concurrent checks on the ports of the scalar arithmetic unit.
`timescale 1ns/100ps
module sanc_scalar_alu_monitor
  import sanc_pkg::*;
(
  input wire logic                    sys_clk_i,
  input wire logic                    reset_i,
  input wire logic                    issue_valid_i,
  input wire sanc_op_type             issue_op_i,
  input wire logic [SANC_DEST_W-1:0]  issue_dest_i,
  input wire logic [SANC_DATA_W-1:0]  src_a_i,
  input wire logic [SANC_DATA_W-1:0]  src_b_i,
  input wire logic                    wb1_valid_o,
  input wire logic [SANC_DEST_W-1:0]  wb1_dest_o,
  input wire logic [SANC_DATA_W-1:0]  wb1_data_o,
  input wire logic                    wb1_overflow_o,
  input wire logic                    wb3_valid_o,
  input wire logic [SANC_DATA_W-1:0]  wb3_data_o,
  input wire logic                    wb4_valid_o,
  input wire logic [SANC_DEST_W-1:0]  wb4_dest_o
);
  logic        mul_w;
  logic        long_w;
  logic        one_w;
  logic [31:0] sum_w;
  logic [31:0] prod_w;

  assign mul_w  = issue_valid_i && issue_op_i == op_mul;
  assign long_w = issue_valid_i && issue_op_i inside {op_sincos, op_fsqrt, op_frsqrt, op_frecip};
  assign one_w  = issue_valid_i && !mul_w && !long_w;
  assign sum_w  = src_a_i + src_b_i;
  assign prod_w = src_a_i * src_b_i;

  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  property p_wb1_lat;
    one_w |=> wb1_valid_o && wb1_dest_o == $past(issue_dest_i);
  endproperty
  a_wb1_lat: assert property (p_wb1_lat) else $error("short result late");
  property p_wb1_idle;
    !one_w |=> !wb1_valid_o;
  endproperty
  a_wb1_idle: assert property (p_wb1_idle) else $error("stray short result");
  property p_mul;
    mul_w |-> ##3 wb3_valid_o && wb3_data_o == $past(prod_w, 3);
  endproperty
  a_mul: assert property (p_mul) else $error("product wrong or late");
  property p_long_lat;
    long_w |-> ##4 wb4_valid_o && wb4_dest_o == $past(issue_dest_i, 4);
  endproperty
  a_long_lat: assert property (p_long_lat) else $error("long result late");
  property p_wb4_cause;
    wb4_valid_o |-> $past(long_w, 4);
  endproperty
  a_wb4_cause: assert property (p_wb4_cause) else $error("stray long result");
  property p_add;
    issue_valid_i && issue_op_i == op_add |=> wb1_data_o == $past(sum_w);
  endproperty
  a_add: assert property (p_add) else $error("sum wrong");
  property p_clz;
    issue_valid_i && issue_op_i == leading_zero_count_op && src_a_i == 32'h0
      |=> wb1_data_o == 32'h00000020;
  endproperty
  a_clz: assert property (p_clz) else $error("zero count wrong");
  property p_min_flag;
    issue_valid_i && issue_op_i == float_to_fixed_conv
      |=> wb1_data_o != SANC_INT_MIN || wb1_overflow_o;
  endproperty
  a_min_flag: assert property (p_min_flag) else $error("flag missing");

  c_overlap: cover property (wb1_valid_o && wb3_valid_o);
  c_long: cover property (long_w ##4 wb4_valid_o);
  c_flag: cover property (wb1_valid_o && wb1_overflow_o);
endmodule : sanc_scalar_alu_monitor

bind sanc_scalar_alu sanc_scalar_alu_monitor i_sanc_scalar_alu_monitor (.*);

// ==== verification/sanc_regfile_model.sv ====
// Register file taking all three write ports at once.
`timescale 1ns/100ps
module sanc_regfile_model
  import sanc_pkg::*;
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   wb1_valid_i,
  input  wire logic [SANC_DEST_W-1:0] wb1_dest_i,
  input  wire logic [SANC_DATA_W-1:0] wb1_data_i,
  input  wire logic                   wb3_valid_i,
  input  wire logic [SANC_DEST_W-1:0] wb3_dest_i,
  input  wire logic [SANC_DATA_W-1:0] wb3_data_i,
  input  wire logic                   wb4_valid_i,
  input  wire logic [SANC_DEST_W-1:0] wb4_dest_i,
  input  wire logic [SANC_DATA_W-1:0] wb4_data_i,
  output logic      [SANC_DATA_W-1:0] regs_o [16]
);
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < 16; i++)
        regs_o[i] <= '0;
    end
    else
    begin
      if (wb1_valid_i)
        regs_o[wb1_dest_i] <= wb1_data_i;
      if (wb3_valid_i)
        regs_o[wb3_dest_i] <= wb3_data_i;
      if (wb4_valid_i)
        regs_o[wb4_dest_i] <= wb4_data_i;
    end
  end
endmodule : sanc_regfile_model

// ==== verification/scalar_alu_nonlinear_convert_test.sv ====
// Self-checking bench for the scalar arithmetic unit.
`timescale 1ns/100ps
module scalar_alu_nonlinear_convert_test
  import sanc_pkg::*;
;
  typedef struct {
    int          due;
    logic [3:0]  dest;
    logic [31:0] data;
    logic        ovf;
    int          tol;
  } sanc_exp_type;

  logic         sys_clk_i, reset_i, issue_valid_i, shift_neg_i;
  sanc_op_type  issue_op_i;
  logic [3:0]   issue_dest_i;
  logic [31:0]  src_a_i, src_b_i;
  logic [5:0]   point_i;
  logic         wb1_valid_o, wb1_overflow_o, wb3_valid_o, wb4_valid_o;
  logic [3:0]   wb1_dest_o, wb3_dest_o, wb4_dest_o;
  logic [31:0]  wb1_data_o, wb3_data_o, wb4_data_o;
  logic [31:0]  regs [16];
  int           fail_count, compares, cyc;
  sanc_exp_type q1[$], q3[$], q4[$];

  sanc_scalar_alu i_sanc_scalar_alu (.*);

  sanc_regfile_model i_sanc_regfile_model (
    .sys_clk_i, .reset_i, .wb1_valid_i(wb1_valid_o), .wb1_dest_i(wb1_dest_o),
    .wb1_data_i(wb1_data_o), .wb3_valid_i(wb3_valid_o), .wb3_dest_i(wb3_dest_o),
    .wb3_data_i(wb3_data_o), .wb4_valid_i(wb4_valid_o), .wb4_dest_i(wb4_dest_o),
    .wb4_data_i(wb4_data_o), .regs_o(regs));

  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    compares++;
    if (seen !== want)
    begin
      fail_count++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  function automatic logic [31:0] fkey(input logic [31:0] a);
    return a[31] ? ~a : a | 32'h80000000;
  endfunction : fkey

  function automatic logic [31:0] model_op(input sanc_op_type op, input logic [31:0] a,
                                           input logic [31:0] b, input logic n);
    int amt;
    amt = n ? -int'(b) : int'(b);
    case (op)
      op_add:                return a + b;
      op_sub:                return a - b;
      bitwise_and_op:        return a & b;
      bitwise_or_op:         return a | b;
      bitwise_xor_op:        return a ^ b;
      op_mul:                return a * b;
      absolute_value_op:     return a[31] ? ~a + 32'h1 : a;
      lesser_select_op:      return $signed(a) < $signed(b) ? a : b;
      greater_select_op:     return $signed(a) > $signed(b) ? a : b;
      op_fabs:               return {1'b0, a[30:0]};
      op_fmin:               return fkey(a) < fkey(b) ? a : b;
      op_fmax:               return fkey(a) > fkey(b) ? a : b;
      leading_zero_count_op:
      begin
        for (int i = 0; i < 32; i++)
          if (a[31-i]) return i;
        return 32;
      end
      default:
      begin
        if (amt >= 32) return '0;
        if (amt >= 0) return a << amt;
        if (amt > -32) return $unsigned($signed(a) >>> -amt);
        return {32{a[31]}};
      end
    endcase
  endfunction : model_op

  function automatic logic near(input logic [31:0] x, input logic [31:0] w, input int tol);
    int dh;
    int dl;
    dh = int'($signed(x[31:16])) - int'($signed(w[31:16]));
    dl = int'($signed(x[15:0])) - int'($signed(w[15:0]));
    return !$isunknown(x) && dh <= tol && dh >= -tol && dl <= tol && dl >= -tol;
  endfunction : near

  task automatic issue(input sanc_op_type op, input logic [3:0] d, input logic [31:0] a,
                       input logic [31:0] w, input logic [5:0] p = 6'h00,
                       input logic f = 1'bx, input int tol = 0,
                       input logic [31:0] b = 32'h0, input logic n = 1'b0);
    sanc_exp_type e;
    int           lat;
    @(posedge sys_clk_i);
    issue_valid_i <= 1'b1;
    issue_op_i <= op;
    issue_dest_i <= d;
    src_a_i <= a;
    src_b_i <= b;
    shift_neg_i <= n;
    point_i <= p;
    lat = op == op_mul ? 3 : op inside {op_sincos, op_fsqrt, op_frsqrt, op_frecip} ? 4 : 1;
    e = '{cyc + lat, d, w, f, tol};
    if (lat == 1) q1.push_back(e);
    else if (lat == 3) q3.push_back(e);
    else q4.push_back(e);
  endtask : issue

  task automatic chk_port(input logic v, input logic [3:0] d, input logic [31:0] x,
                          input logic f, ref sanc_exp_type q[$]);
    if (q.size() > 0 && q[0].due == cyc)
    begin
      check(v, 1, "valid");
      check(d, q[0].dest, "dest");
      if (q[0].tol > 0) check(near(x, q[0].data, q[0].tol), 1, "sincos");
      else check(x, q[0].data, "data");
      if (q[0].ovf !== 1'bx) check(f, q[0].ovf, "overflow");
      void'(q.pop_front());
    end
    else check(v, 0, "idle");
  endtask : chk_port

  task automatic drain(input string name);
    int n;
    @(posedge sys_clk_i);
    issue_valid_i <= 1'b0;
    for (n = 0; n < 20 && q1.size() + q3.size() + q4.size() > 0; n++) @(posedge sys_clk_i);
    if (n == 20)
    begin
      fail_count++;
      $display("BAD %0t %s results missing", $time, name);
      tally_and_finish();
    end
    else $display("test %s done", name);
  endtask : drain

  always @(negedge sys_clk_i)
  begin
    if (!reset_i)
    begin
      chk_port(wb1_valid_o, wb1_dest_o, wb1_data_o, wb1_overflow_o, q1);
      chk_port(wb3_valid_o, wb3_dest_o, wb3_data_o, 1'b0, q3);
      chk_port(wb4_valid_o, wb4_dest_o, wb4_data_o, 1'b0, q4);
    end
    cyc++;
  end

  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  initial
  begin
    #20000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    sanc_op_type op;
    logic [31:0] a, b;
    logic        n;
    reset_i = 1'b1;
    issue_valid_i = 1'b0;
    issue_op_i = op_add;
    issue_dest_i = '0;
    src_a_i = '0;
    src_b_i = '0;
    shift_neg_i = 1'b0;
    point_i = '0;
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    void'($urandom(69277));
    for (int i = 0; i < 300; i++)
    begin
      op = sanc_op_type'($urandom_range(17));
      if (op inside {op_sincos, op_fsqrt, op_frsqrt, op_frecip}) op = op_shift;
      a = i % 8 == 0 ? 32'h80000000 : $urandom;
      b = op == op_shift ? $urandom_range(80) - 40 : $urandom;
      n = 1'($urandom);
      issue(op, 4'($urandom), a, model_op(op, a, b, n), 6'h00, 1'bx, 0, b, n);
    end
    drain("random");
    // In-range inputs, plus the underflow, huge and saturating cases.
    issue(fixed_to_float_conv, 4'h3, 32'h3, 32'h3FC00000, 6'h01);
    issue(fixed_to_float_conv, 4'h4, 32'hFFFFFFFE, 32'hC0000000);
    issue(float_to_fixed_conv, 4'h5, 32'h3FC00000, 32'h3, 6'h01, 1'b0);
    issue(float_to_fixed_conv, 4'h6, 32'h4F000000, 32'h40000000, 6'h3F, 1'b0);
    issue(float_to_fixed_conv, 4'h7, 32'h4F000000, 32'h0, 6'h20, 1'b0);
    issue(float_to_fixed_conv, 4'h8, 32'h7F000000, 32'h0, 6'h05, 1'b1);
    issue(float_to_fixed_conv, 4'h9, 32'hBF800000, 32'h80000000, 6'h1F, 1'b1);
    issue(leading_zero_count_op, 4'h2, 32'h0, 32'h20);
    drain("convert");
    issue(op_sincos, 4'hA, 32'h0, 32'h00007FFF, 6'h00, 1'bx, 4);
    issue(op_sincos, 4'hB, 32'h40000000, 32'h7FFF0000, 6'h00, 1'bx, 4);
    issue(op_sincos, 4'hC, 32'h80000000, 32'h00008000, 6'h00, 1'bx, 4);
    // Float operands only.
    issue(op_fsqrt, 4'hD, 32'h40800000, 32'h40000000);
    issue(op_frsqrt, 4'hE, 32'h40800000, 32'h3F000000);
    issue(op_frecip, 4'hF, 32'h40000000, 32'h3F000000);
    issue(op_fsqrt, 4'h0, 32'hBF800000, 32'h7FC00000);
    drain("long");
    // Multiply and add write on one cycle.
    issue(op_mul, 4'h1, 32'h3, 32'hF, 6'h00, 1'bx, 0, 32'h5);
    issue(op_sub, 4'h2, 32'h0, 32'hFFFFFFFF, 6'h00, 1'bx, 0, 32'h1);
    issue(op_add, 4'h3, 32'h1, 32'h3, 6'h00, 1'bx, 0, 32'h2);
    drain("overlap");
    @(negedge sys_clk_i);
    check(regs[1], 32'h0000000F, "reg 1");
    check(regs[3], 32'h00000003, "reg 3");
    tally_and_finish();
  end
endmodule : scalar_alu_nonlinear_convert_test
